// ---- design/host_port_pkg.sv ----
// host port package: pin bundle, word addresses, reset values, delays
// assumes a 16-bit sram-like host bus sampled on clk_sys at 250 MHz
package host_port_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 4; // clk_sys period
	localparam int TX_LEVEL_MAX_NS = 165; // longest lag of tx level update
	localparam int CFG_SETTLE_NS = 165; // config write side effect lag
	localparam int PM_SETTLE_NS = 330; // power control side effect lag
	// longest times round down to whole cycles
	localparam int TX_LEVEL_MAX_CYC = TX_LEVEL_MAX_NS / CLK_PERIOD_NS;
	localparam int CFG_SETTLE_CYC = CFG_SETTLE_NS / CLK_PERIOD_NS;
	localparam int PM_SETTLE_CYC = PM_SETTLE_NS / CLK_PERIOD_NS;
	localparam int SETTLE_W = 7; // holds counts up to 127
	// pin change to fetch or commit; a read pays it too, so the settle
	// count is cut by it or a host keeping the gap would see stale data
	localparam int SYNC_LAG_CYC = 3;

	// ****************************************
	// widths
	// ****************************************
	localparam int DATA_W = 16;
	localparam int ADDR_W = 7; // word address, byte lane bit dropped
	localparam int TX_LEVEL_W = 12;

	// ****************************************
	// word addresses
	// ****************************************
	localparam logic [6:0] ADDR_RX_DATA = 7'h00;
	localparam logic [6:0] ADDR_TX_DATA = 7'h10;
	localparam logic [6:0] ADDR_IDENT = 7'h28;
	localparam logic [6:0] ADDR_BYTE_TEST = 7'h32;
	localparam logic [6:0] ADDR_HW_CONFIG = 7'h3a;
	localparam logic [6:0] ADDR_RX_FIFO_INFO = 7'h3c;
	localparam logic [6:0] ADDR_TX_FIFO_INFO = 7'h40;
	localparam logic [6:0] ADDR_PM_CONTROL = 7'h42;
	localparam logic [6:0] ADDR_RX_DROP = 7'h50;

	// ****************************************
	// reset and fixed values
	// ****************************************
	localparam logic [15:0] IDENT_VALUE = 16'h5a01; // arbitrary value
	localparam logic [15:0] BYTE_TEST_VALUE = 16'h4321; // arbitrary value
	localparam logic [15:0] HW_CONFIG_RESET = 16'h0000;
	localparam logic [15:0] PM_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] ZERO_WORD = 16'h0000;

	// host pins as seen by the device
	typedef struct packed {
		logic chip_select_n;
		logic read_strobe_n;
		logic write_strobe_n;
		logic fifo_sel; // direct fifo access, high order address
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} host_pins_t;

	// host port cycle state
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE
	} port_state_t;

endpackage

// ---- design/settle_timer.sv ----
// settle timer: one pulse a fixed number of cycles after start
// assumes start is a one-cycle pulse from clk_sys logic
`timescale 1ns/100ps
`default_nettype none
module settle_timer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// control
	input wire logic start,
	input wire logic [host_port_pkg::SETTLE_W-1:0] delay,
	// result
	output logic done
);
	import host_port_pkg::*;

	logic [SETTLE_W-1:0] count_reg, count_next; // cycles left
	logic busy_reg, busy_next; // counting
	logic done_reg, done_next; // expiry pulse

	// ****************************************
	// countdown, a restart pushes the expiry out
	// ****************************************
	always_comb begin
		count_next = count_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		if (start) begin
			count_next = delay;
			busy_next = 1'b1;
		end else if (busy_reg) begin
			// delay of one or less expires at once
			if (count_reg <= SETTLE_W'(1)) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end else begin
				count_next = count_reg - SETTLE_W'(1);
			end
		end
	end

	// registers only
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			count_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign done = done_reg;

endmodule
`default_nettype wire

// ---- design/host_port.sv ----
// host port: sram-like 16-bit device side with fifo windows
// assumes host pins are asynchronous; core side runs on clk_sys
`timescale 1ns/100ps
`default_nettype none
module host_port (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// host pins
	input wire host_port_pkg::host_pins_t pins,
	output logic [host_port_pkg::DATA_W-1:0] data_out,
	output logic data_oe,
	// receive side of the core
	input wire logic [host_port_pkg::DATA_W-1:0] rx_data,
	input wire logic [host_port_pkg::DATA_W-1:0] rx_info,
	input wire logic rx_dropped,
	output logic rx_pop,
	// transmit side of the core
	output logic [host_port_pkg::DATA_W-1:0] tx_word,
	output logic tx_push,
	input wire logic tx_taken,
	// configuration seen by the core
	output logic [host_port_pkg::DATA_W-1:0] hw_config,
	output logic [host_port_pkg::DATA_W-1:0] pm_control
);
	import host_port_pkg::*;

	// ****************************************
	// pin synchroniser
	// ****************************************
	host_pins_t sync1_reg, sync2_reg; // first stage feeds second only

	// pins are asynchronous to clk_sys, two stages before use
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			sync1_reg <= '{1'b1, 1'b1, 1'b1, 1'b0, '0, '0};
			sync2_reg <= '{1'b1, 1'b1, 1'b1, 1'b0, '0, '0};
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
		end
	end

	logic rd_act; // read strobe pair asserted
	logic wr_act; // write strobe pair asserted
	// either strobe deasserting ends a cycle, so cs or strobe controls
	assign rd_act = !sync2_reg.chip_select_n && !sync2_reg.read_strobe_n;
	assign wr_act = !sync2_reg.chip_select_n && !sync2_reg.write_strobe_n;

	// ****************************************
	// state
	// ****************************************
	port_state_t state_reg, state_next; // cycle tracking
	logic [ADDR_W-1:0] addr_reg, addr_next; // address of last fetch or write
	logic sel_reg, sel_next; // fifo_sel of last fetch or write
	logic [DATA_W-1:0] data_out_reg, data_out_next;
	logic data_oe_reg, data_oe_next;
	logic rx_pop_reg, rx_pop_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next; // last data seen in write
	logic [DATA_W-1:0] tx_word_reg, tx_word_next;
	logic tx_push_reg, tx_push_next;
	logic [TX_LEVEL_W-1:0] tx_level_reg, tx_level_next; // words queued
	logic [DATA_W-1:0] rx_drop_reg, rx_drop_next; // dropped frames
	logic [DATA_W-1:0] hw_pend_reg, hw_pend_next; // written, not applied
	logic [DATA_W-1:0] pm_pend_reg, pm_pend_next;
	logic [DATA_W-1:0] hw_config_reg, hw_config_next;
	logic [DATA_W-1:0] pm_control_reg, pm_control_next;
	logic hw_start, pm_start; // write lands in a settling register
	logic hw_done, pm_done; // side effect becomes visible
	logic [DATA_W-1:0] rd_word; // addressed word

	// ****************************************
	// read mux, values from flops, constants or the core side inputs
	// ****************************************
	always_comb begin
		rd_word = ZERO_WORD;
		if (sync2_reg.fifo_sel) begin
			rd_word = rx_data; // direct fifo read ignores the address
		end else begin
			unique case (sync2_reg.addr)
				ADDR_RX_DATA: rd_word = rx_data;
				ADDR_IDENT: rd_word = IDENT_VALUE;
				ADDR_BYTE_TEST: rd_word = BYTE_TEST_VALUE;
				ADDR_RX_FIFO_INFO: rd_word = rx_info;
				ADDR_RX_DROP: rd_word = rx_drop_reg;
				ADDR_TX_FIFO_INFO: rd_word = DATA_W'(tx_level_reg);
				ADDR_HW_CONFIG: rd_word = hw_config_reg;
				ADDR_PM_CONTROL: rd_word = pm_control_reg;
				default: rd_word = ZERO_WORD; // unmapped reads as zero
			endcase
		end
	end

	// ****************************************
	// cycle decode, read fetch and write commit
	// ****************************************
	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		sel_next = sel_reg;
		data_out_next = data_out_reg;
		data_oe_next = 1'b0;
		rx_pop_next = 1'b0;
		wdata_next = wdata_reg;
		tx_word_next = tx_word_reg;
		tx_push_next = 1'b0;
		hw_start = 1'b0;
		pm_start = 1'b0;
		hw_pend_next = hw_pend_reg;
		pm_pend_next = pm_pend_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (rd_act) begin
					// pio or direct read starts, fetch at once
					state_next = ST_READ;
					addr_next = sync2_reg.addr;
					sel_next = sync2_reg.fifo_sel;
					data_out_next = rd_word;
					data_oe_next = 1'b1;
					rx_pop_next = sync2_reg.fifo_sel ||
						(sync2_reg.addr == ADDR_RX_DATA);
				end else if (wr_act) begin
					state_next = ST_WRITE;
					addr_next = sync2_reg.addr;
					sel_next = sync2_reg.fifo_sel;
					wdata_next = sync2_reg.data;
				end
			end
			ST_READ: begin
				if (!rd_act) begin
					state_next = ST_IDLE; // drive off at cycle end
				end else begin
					data_oe_next = 1'b1;
					// burst: a new address inside one strobe refetches
					if (sync2_reg.addr != addr_reg ||
						sync2_reg.fifo_sel != sel_reg) begin
						addr_next = sync2_reg.addr;
						sel_next = sync2_reg.fifo_sel;
						data_out_next = rd_word;
						rx_pop_next = sync2_reg.fifo_sel ||
							(sync2_reg.addr == ADDR_RX_DATA);
					end
				end
			end
			ST_WRITE: begin
				if (wr_act) begin
					// data settles late, keep the newest sample
					wdata_next = sync2_reg.data;
				end else begin
					// commit at the trailing strobe edge
					state_next = ST_IDLE;
					if (sel_reg || addr_reg == ADDR_TX_DATA) begin
						tx_word_next = wdata_reg;
						tx_push_next = 1'b1;
					end else if (addr_reg == ADDR_HW_CONFIG) begin
						hw_pend_next = wdata_reg;
						hw_start = 1'b1;
					end else if (addr_reg == ADDR_PM_CONTROL) begin
						pm_pend_next = wdata_reg;
						pm_start = 1'b1;
					end
					// other addresses are read only, write ignored
				end
			end
		endcase
	end

	// ****************************************
	// side effects: levels, counters, delayed configuration
	// ****************************************
	always_comb begin
		tx_level_next = tx_level_reg;
		// level follows the push one cycle later, well inside the limit
		if (tx_push_reg && !tx_taken) begin
			tx_level_next = tx_level_reg + TX_LEVEL_W'(1);
		end else if (!tx_push_reg && tx_taken && tx_level_reg != '0) begin
			tx_level_next = tx_level_reg - TX_LEVEL_W'(1);
		end
		rx_drop_next = rx_drop_reg;
		if (rx_dropped) begin
			rx_drop_next = rx_drop_reg + DATA_W'(1);
		end
		// applied values lag writes, readers must wait
		hw_config_next = hw_done ? hw_pend_reg : hw_config_reg;
		pm_control_next = pm_done ? pm_pend_reg : pm_control_reg;
	end

	settle_timer u_hw_settle (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.start(hw_start),
		.delay(SETTLE_W'(CFG_SETTLE_CYC - SYNC_LAG_CYC)),
		.done(hw_done)
	);

	settle_timer u_pm_settle (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.start(pm_start),
		.delay(SETTLE_W'(PM_SETTLE_CYC - SYNC_LAG_CYC)),
		.done(pm_done)
	);

	// registers only
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			addr_reg <= '0;
			sel_reg <= 1'b0;
			data_out_reg <= ZERO_WORD;
			data_oe_reg <= 1'b0;
			rx_pop_reg <= 1'b0;
			wdata_reg <= ZERO_WORD;
			tx_word_reg <= ZERO_WORD;
			tx_push_reg <= 1'b0;
			tx_level_reg <= '0;
			rx_drop_reg <= ZERO_WORD;
			hw_pend_reg <= HW_CONFIG_RESET;
			pm_pend_reg <= PM_CONTROL_RESET;
			hw_config_reg <= HW_CONFIG_RESET;
			pm_control_reg <= PM_CONTROL_RESET;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			sel_reg <= sel_next;
			data_out_reg <= data_out_next;
			data_oe_reg <= data_oe_next;
			rx_pop_reg <= rx_pop_next;
			wdata_reg <= wdata_next;
			tx_word_reg <= tx_word_next;
			tx_push_reg <= tx_push_next;
			tx_level_reg <= tx_level_next;
			rx_drop_reg <= rx_drop_next;
			hw_pend_reg <= hw_pend_next;
			pm_pend_reg <= pm_pend_next;
			hw_config_reg <= hw_config_next;
			pm_control_reg <= pm_control_next;
		end
	end

	assign data_out = data_out_reg;
	assign data_oe = data_oe_reg;
	assign rx_pop = rx_pop_reg;
	assign tx_word = tx_word_reg;
	assign tx_push = tx_push_reg;
	assign hw_config = hw_config_reg;
	assign pm_control = pm_control_reg;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	read_drive_a: assert property (
		(state_reg == ST_IDLE && rd_act) |=> data_oe && state_reg == ST_READ)
		else $error("read start did not drive the bus");
	read_release_a: assert property (
		(state_reg == ST_READ && !rd_act) |=> !data_oe)
		else $error("bus still driven after read end");
	write_push_a: assert property (
		(state_reg == ST_WRITE && !wr_act && sel_reg) |=>
			tx_push && tx_word == $past(wdata_reg))
		else $error("direct fifo write not pushed");
	tx_level_a: assert property (
		(tx_push && !tx_taken && tx_level_reg != '1) |=>
			tx_level_reg == $past(tx_level_reg) + TX_LEVEL_W'(1))
		else $error("tx level not updated in time");
	ident_zero_a: assert property (
		(state_reg == ST_IDLE && rd_act && !sync2_reg.fifo_sel &&
			sync2_reg.addr == ADDR_IDENT) |=> data_out == IDENT_VALUE)
		else $error("ident read wrong or late");
	byte_test_a: assert property (
		(state_reg == ST_IDLE && rd_act && !sync2_reg.fifo_sel &&
			sync2_reg.addr == ADDR_BYTE_TEST) |=> data_out == BYTE_TEST_VALUE)
		else $error("byte test read wrong or late");
	hw_settle_a: assert property (
		(hw_start ##1 !hw_start [*8]) |-> hw_config == $past(hw_config, 8))
		else $error("hw config changed before settle time");

	rd_cover_c: cover property (state_reg == ST_READ && rx_pop);
	burst_cover_c: cover property (state_reg == ST_READ && $changed(addr_reg));
	tx_cover_c: cover property (tx_push);
	pm_cover_c: cover property (pm_done);

endmodule
`default_nettype wire

// ---- verification/host_model.sv ----
// host model: cpu side of the sram-like port, keeps write-read gaps
// assumes tasks are called just after a clk_sys rising edge
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// clock
	input wire logic clk_sys,
	// pins toward the device
	output var host_port_pkg::host_pins_t pins,
	input wire logic [host_port_pkg::DATA_W-1:0] data_out,
	input wire logic data_oe
);
	import host_port_pkg::*;
	// ****************************************
	// bus timing of this host
	// ****************************************
	localparam int RD_CYC = 48; // slower than minimum cycle, still legal
	int cyc = 0; // free running cycle count
	int last_wr = -1000; // cycle at which the last write ended
	initial pins = '{1'b1, 1'b1, 1'b1, 1'b0, 7'h00, 16'h0000};
	// time base for the write-read gap
	always @(posedge clk_sys) cyc <= cyc + 1;

	// cycles owed after a write, set by the register about to be read
	function automatic int need(input logic [6:0] a);
		case (a)
			ADDR_HW_CONFIG, ADDR_TX_FIFO_INFO: need =
				(CFG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
			ADDR_PM_CONTROL: need =
				(PM_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
			default: need = 0; // no gap owed
		endcase
	endfunction

	// one read, padded so each read spans RD_CYC cycles
	task automatic cycle_rd(input logic [6:0] a, input logic fs,
		output logic [15:0] d);
		int n;
		n = 0;
		d = 'x;
		pins.chip_select_n <= 1'b0;
		pins.read_strobe_n <= 1'b0;
		pins.addr <= a;
		pins.fifo_sel <= fs;
		// bounded wait for the device to drive the bus
		while (data_oe !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			n++;
		end
		if (data_oe === 1'b1) d = data_out;
		pins.chip_select_n <= 1'b1;
		pins.read_strobe_n <= 1'b1;
		while (n < RD_CYC) begin
			@(posedge clk_sys);
			n++;
		end
	endtask

	// two words in one strobe, each address held RD_CYC cycles
	task automatic burst_rd(input logic [6:0] a0, a1, input logic fs,
		output logic [15:0] d0, d1);
		int n;
		n = 0;
		d0 = 'x;
		d1 = 'x;
		pins.chip_select_n <= 1'b0;
		pins.read_strobe_n <= 1'b0;
		pins.addr <= a0;
		pins.fifo_sel <= fs;
		while (data_oe !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			n++;
		end
		if (data_oe === 1'b1) d0 = data_out;
		while (n < RD_CYC) begin
			@(posedge clk_sys);
			n++;
		end
		pins.addr <= a1; // refetch inside the strobe
		// two sync stages plus the fetch register
		repeat (4) @(posedge clk_sys);
		if (data_oe === 1'b1) d1 = data_out;
		repeat (RD_CYC - 4) @(posedge clk_sys);
		pins.chip_select_n <= 1'b1;
		pins.read_strobe_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask

	// target read, gap filled by idle cycles or byte test reads
	task automatic rd(input logic [6:0] a, input logic fs, input bit idle,
		output logic [15:0] d);
		logic [15:0] junk;
		while (cyc - last_wr < need(a)) begin
			if (idle) begin
				@(posedge clk_sys); // plain idle time
			end else begin
				cycle_rd(ADDR_BYTE_TEST, 1'b0, junk); // dummy read
			end
		end
		cycle_rd(a, fs, d);
	endtask

	// one write; data held past the strobe release, then scrambled
	task automatic wr(input logic [6:0] a, input logic fs,
		input logic [15:0] v);
		pins.chip_select_n <= 1'b0;
		pins.write_strobe_n <= 1'b0;
		pins.addr <= a;
		pins.fifo_sel <= fs;
		pins.data <= v;
		repeat (4) @(posedge clk_sys);
		pins.chip_select_n <= 1'b1;
		pins.write_strobe_n <= 1'b1;
		last_wr = cyc; // gap counts from here
		repeat (3) @(posedge clk_sys);
		pins.data <= ~v; // released bus shows no stale word
		@(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// testbench: host model against host_port, core side driven here
// assumes host_port_pkg compiled first; clk_sys 250 MHz
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import host_port_pkg::*;
	logic clk_sys, nrst, data_oe, rx_dropped, rx_pop, tx_push, tx_taken;
	host_pins_t pins;
	logic [15:0] data_out, rx_data, rx_info, tx_word, hw_config, pm_control;
	logic [15:0] rd_val, last_tx;
	int err_total = 0, num_checks = 0, push_cnt = 0, pop_cnt = 0;

	host_port i_dut (.clk_sys, .nrst, .pins, .data_out, .data_oe,
		.rx_data, .rx_info, .rx_dropped, .rx_pop, .tx_word, .tx_push,
		.tx_taken, .hw_config, .pm_control);
	host_model i_host (.clk_sys, .pins, .data_out, .data_oe);

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// count core side pulses as they happen
	always @(posedge clk_sys) begin
		if (tx_push === 1'b1) begin
			push_cnt++;
			last_tx = tx_word;
		end
		if (rx_pop === 1'b1) pop_cnt++;
	end

	// ****************************************
	// checking and closing
	// ****************************************
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic pulse_taken;
		tx_taken <= 1'b1;
		@(posedge clk_sys);
		tx_taken <= 1'b0;
		@(posedge clk_sys);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	// zero wait reads straight after a config write, then the config
	task automatic t_zero_wait;
		repeat (3) begin
			rx_dropped <= 1'b1;
			@(posedge clk_sys);
			rx_dropped <= 1'b0;
			@(posedge clk_sys);
		end
		i_host.wr(ADDR_HW_CONFIG, 1'b0, 16'h00a5);
		i_host.rd(ADDR_IDENT, 1'b0, 1'b0, rd_val);
		chk("ident", rd_val, IDENT_VALUE);
		i_host.rd(ADDR_BYTE_TEST, 1'b0, 1'b0, rd_val);
		chk("byte test", rd_val, BYTE_TEST_VALUE);
		i_host.rd(ADDR_RX_FIFO_INFO, 1'b0, 1'b0, rd_val);
		chk("rx info", rd_val, 16'h0a0b);
		i_host.rd(ADDR_RX_DROP, 1'b0, 1'b0, rd_val);
		chk("rx drop", rd_val, 16'h0003);
		i_host.rd(ADDR_HW_CONFIG, 1'b0, 1'b0, rd_val);
		chk("hw config read", rd_val, 16'h00a5);
		chk("hw config port", hw_config, 16'h00a5);
	endtask
	// power control needs the long gap; other target after same write
	task automatic t_power;
		i_host.wr(ADDR_PM_CONTROL, 1'b0, 16'h0003);
		i_host.rd(ADDR_HW_CONFIG, 1'b0, 1'b0, rd_val);
		chk("hw config kept", rd_val, 16'h00a5);
		i_host.rd(ADDR_PM_CONTROL, 1'b0, 1'b0, rd_val);
		chk("pm read", rd_val, 16'h0003);
		chk("pm port", pm_control, 16'h0003);
		// idle gap of exactly the wait, no dummy reads
		i_host.wr(ADDR_HW_CONFIG, 1'b0, 16'h005a);
		i_host.rd(ADDR_HW_CONFIG, 1'b0, 1'b1, rd_val);
		chk("hw config tight", rd_val, 16'h005a);
		i_host.wr(ADDR_PM_CONTROL, 1'b0, 16'h0001);
		i_host.rd(ADDR_PM_CONTROL, 1'b0, 1'b1, rd_val);
		chk("pm tight", rd_val, 16'h0001);
	endtask
	// burst reads: a new address inside one strobe refetches
	task automatic t_burst;
		logic [15:0] b0, b1;
		i_host.burst_rd(ADDR_IDENT, ADDR_BYTE_TEST, 1'b0, b0, b1);
		chk("burst first", b0, IDENT_VALUE);
		chk("burst second", b1, BYTE_TEST_VALUE);
		rx_data <= 16'h9abc;
		i_host.burst_rd(7'h01, 7'h02, 1'b1, b0, b1);
		chk("fifo burst first", b0, 16'h9abc);
		chk("fifo burst second", b1, 16'h9abc);
		chk("pop burst", 16'(pop_cnt), 16'h0004);
	endtask
	// direct and programmed tx writes, level follows push and drain
	task automatic t_tx;
		i_host.wr(7'h05, 1'b1, 16'hbeef);
		// let the pulse counter see the push before looking
		@(posedge clk_sys);
		chk("push count", 16'(push_cnt), 16'h0001);
		chk("tx word", last_tx, 16'hbeef);
		i_host.rd(ADDR_TX_FIFO_INFO, 1'b0, 1'b1, rd_val);
		chk("tx level one", {4'h0, rd_val[11:0]}, 16'h0001);
		i_host.wr(ADDR_TX_DATA, 1'b0, 16'h1357);
		@(posedge clk_sys);
		chk("tx word pio", last_tx, 16'h1357);
		i_host.rd(ADDR_TX_FIFO_INFO, 1'b0, 1'b0, rd_val);
		chk("tx level two", {4'h0, rd_val[11:0]}, 16'h0002);
		pulse_taken();
		pulse_taken();
		i_host.rd(ADDR_TX_FIFO_INFO, 1'b0, 1'b0, rd_val);
		chk("tx level zero", {4'h0, rd_val[11:0]}, 16'h0000);
	endtask
	// rx fifo through the direct window and the programmed address
	task automatic t_rx;
		rx_data <= 16'h1234;
		i_host.rd(7'h55, 1'b1, 1'b0, rd_val);
		chk("rx direct", rd_val, 16'h1234);
		chk("pop direct", 16'(pop_cnt), 16'h0001);
		rx_data <= 16'h5678;
		i_host.rd(ADDR_RX_DATA, 1'b0, 1'b0, rd_val);
		chk("rx pio", rd_val, 16'h5678);
		chk("pop pio", 16'(pop_cnt), 16'h0002);
	endtask
	// read-only write ignored, unmapped read gives zero
	task automatic t_refuse;
		i_host.wr(ADDR_IDENT, 1'b0, 16'hffff);
		i_host.rd(ADDR_IDENT, 1'b0, 1'b0, rd_val);
		chk("ident kept", rd_val, IDENT_VALUE);
		i_host.rd(7'h7e, 1'b0, 1'b0, rd_val);
		chk("unmapped", rd_val, ZERO_WORD);
	endtask

	initial begin
		nrst = 1'b0;
		rx_data = 16'h0000;
		rx_info = 16'h0a0b;
		rx_dropped = 1'b0;
		tx_taken = 1'b0;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_zero_wait();
		t_power();
		t_tx();
		t_rx();
		t_burst();
		t_refuse();
		test_done();
	end
	// watchdog, well past the roughly 1300 cycles the run needs
	initial begin
		#80000;
		err_total++;
		test_done();
	end
endmodule
`default_nettype wire
